// File: rtl/bus_master_pkg.sv
// Shared constants and types for the pipelined bus master port
package bus_master_pkg;

	localparam int ADDR_W = 34;
	localparam int DATA_W = 32;
	localparam int BE_W = 4;

	// Word address bits below the 16-byte block boundary
	localparam int WORD_SEL_W = 2;

	// Words in one burst line fill
	localparam logic [2:0] BURST_WORDS = 3'h4;
	localparam logic [2:0] SINGLE_WORDS = 3'h1;

	// Beat index whose advance produces the final burst address
	localparam logic [1:0] BEAT_PENULT = 2'h2;
	localparam logic [1:0] BEAT_FIRST = 2'h0;

	// Clocks from the accepting edge to the first read data sample, minus one
	localparam logic [1:0] SINGLE_GAP = 2'h0;
	localparam logic [1:0] BURST_GAP = 2'h1;

	// Burst line fills transfer whole words
	localparam logic [3:0] BE_FULL = 4'hf;

	// Reset values
	localparam logic [33:0] ADDR_RST = 34'h0;
	localparam logic [31:0] DATA_RST = 32'h0;
	localparam logic [3:0] BE_RST = 4'h0;

	typedef enum logic [1:0] {
		OP_READ = 2'h0,
		OP_WRITE = 2'h1,
		OP_BURST = 2'h2
	} op_e;

	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_ADDR = 2'h1,
		ST_DATA = 2'h3
	} state_e;

endpackage

// File: rtl/burst_word_order.sv
// Word selection within a 16-byte block for burst address progression
`timescale 1ns/10ps
module burst_word_order (
	input logic [1:0] start,
	input logic [1:0] step,
	input logic sub_order,
	output logic [1:0] word
);

	wire [1:0] seq_word = 2'(start + step);
	wire [1:0] sub_word = start ^ step;

	assign word = sub_order ? sub_word : seq_word;

endmodule

// File: rtl/pipelined_bus_master_port.sv
// Master end of the pipelined in-order system bus: single read, single write, burst read
//
// Function
// - Put a new address on the bus at once, not waiting for address ready.
// - Hold address and byte enables until the edge after address ready is high.
// - Drive a 34-bit word address and 4-bit byte enables on every transaction.
// - Single read raises instruction flag only for uncached instruction fetches.
// - Address valid is high in every clock a valid address is on the bus.
// - Write direction stays low for reads.
// - Single read samples data one clock after address ready, then until valid.
// - Write raises write direction together with address valid.
// - Write data starts with the address, held until edge after write ready.
// - A burst read moves four words of one aligned block, critical word first.
// - Sequential burst order increments word bits and wraps inside the block.
// - Sub-block burst order is start word xor beat count.
// - Burst indicator is high while any burst address is on the bus.
// - First marker on the first burst address, last marker on the last.
// - Instruction flag is high during a burst that fills the instruction cache.
// - Burst samples data two clocks after address ready, capturing each valid word.
// - Address ready low within a burst holds the current address one more clock.
// - Address valid stays high while any burst address remains on the bus.
`timescale 1ns/10ps
module pipelined_bus_master_port (
	input logic clk_sys,
	input logic rst_b,
	input logic req_valid,
	output logic req_ready,
	input logic [1:0] req_op,
	input logic [33:0] req_addr,
	input logic [3:0] req_be,
	input logic [31:0] req_wdata,
	input logic req_instr,
	output logic rsp_valid,
	output logic [31:0] rsp_data,
	output logic rsp_error,
	output logic rsp_last,
	output logic wr_done,
	output logic wr_error,
	output logic [33:0] bus_word_address,
	output logic [3:0] bus_byte_enables,
	output logic address_valid_out,
	input logic address_ready_in,
	output logic write_direction,
	output logic instruction_fetch_flag,
	output logic burst_indicator,
	output logic burst_first_marker,
	output logic burst_last_marker,
	input logic subblock_order_select,
	input logic [31:0] read_data_in,
	input logic read_valid_in,
	input logic read_bus_error_in,
	output logic [31:0] write_data_out,
	input logic write_data_ready_in,
	input logic write_bus_error_in
);

	bus_master_pkg::state_e state_r, state_nxt;
	logic req_ready_r;
	logic [33:0] addr_r, addr_nxt;
	logic [3:0] be_r, be_nxt;
	logic addr_valid_r, addr_valid_nxt;
	logic write_r, write_nxt;
	logic instr_r, instr_nxt;
	logic burst_r, burst_nxt;
	logic first_r, first_nxt;
	logic last_r, last_nxt;
	logic [1:0] beat_r, beat_nxt;
	logic [1:0] start_r;
	logic sub_r;
	logic [2:0] rd_left_r, rd_left_nxt;
	logic [1:0] rd_wait_r, rd_wait_nxt;
	logic [31:0] wdata_r;
	logic wd_live_r, wd_live_nxt;
	logic wchk_r;
	logic rsp_valid_r, rsp_error_r, rsp_last_r;
	logic [31:0] rsp_data_r;
	logic wr_done_r, wr_error_r;
	logic [1:0] next_word;

	// Request decode
	wire take = req_valid && req_ready_r;
	wire req_burst = req_op == bus_master_pkg::OP_BURST;
	wire req_write = req_op == bus_master_pkg::OP_WRITE;
	wire take_write = take && req_write;

	// Address phase decode
	wire addr_take = addr_valid_r && address_ready_in;
	wire more_beats = burst_r && !last_r;
	wire advance = addr_take && more_beats;
	wire addr_end = addr_take && !more_beats;
	wire rd_first_take = addr_take && !write_r && (!burst_r || first_r);

	// Data phase decode
	wire samp = (rd_left_r != 3'h0) && (rd_wait_r == 2'h0);
	wire got = samp && read_valid_in;
	wire wd_ack = wd_live_r && write_data_ready_in;
	wire all_done = (rd_left_r == 3'h0) && !wd_live_r && !wchk_r;
	wire [1:0] beat_inc = 2'(beat_r + 2'h1);

	burst_word_order u_order (
		.start(start_r),
		.step(beat_inc),
		.sub_order(sub_r),
		.word(next_word)
	);

	assign addr_nxt = take ? req_addr :
		advance ? {addr_r[33:2], next_word} : addr_r;
	assign be_nxt = take ? (req_burst ? bus_master_pkg::BE_FULL : req_be) : be_r;
	assign addr_valid_nxt = take ? 1'b1 : (addr_end ? 1'b0 : addr_valid_r);
	assign write_nxt = take ? req_write : (addr_end ? 1'b0 : write_r);
	assign instr_nxt = take ? (req_instr && !req_write) : (addr_end ? 1'b0 : instr_r);
	assign burst_nxt = take ? req_burst : (addr_end ? 1'b0 : burst_r);
	assign first_nxt = take ? req_burst : ((advance || addr_end) ? 1'b0 : first_r);
	assign last_nxt = take ? 1'b0 :
		advance ? (beat_r == bus_master_pkg::BEAT_PENULT) : (addr_end ? 1'b0 : last_r);
	assign beat_nxt = take ? bus_master_pkg::BEAT_FIRST : (advance ? beat_inc : beat_r);

	assign rd_left_nxt = rd_first_take ?
		(burst_r ? bus_master_pkg::BURST_WORDS : bus_master_pkg::SINGLE_WORDS) :
		(got ? 3'(rd_left_r - 3'h1) : rd_left_r);
	assign rd_wait_nxt = rd_first_take ?
		(burst_r ? bus_master_pkg::BURST_GAP : bus_master_pkg::SINGLE_GAP) :
		((rd_wait_r != 2'h0) ? 2'(rd_wait_r - 2'h1) : rd_wait_r);
	// hold data until write ready seen
	assign wd_live_nxt = take_write ? 1'b1 : (wd_ack ? 1'b0 : wd_live_r);

	// One transaction at a time keeps read data order trivially in step
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			bus_master_pkg::ST_IDLE: begin
				if (take) begin
					state_nxt = bus_master_pkg::ST_ADDR;
				end
			end
			bus_master_pkg::ST_ADDR: begin
				if (addr_end) begin
					state_nxt = bus_master_pkg::ST_DATA;
				end
			end
			bus_master_pkg::ST_DATA: begin
				if (all_done) begin
					state_nxt = bus_master_pkg::ST_IDLE;
				end
			end
			default: begin
				state_nxt = bus_master_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			state_r <= bus_master_pkg::ST_IDLE;
			req_ready_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			req_ready_r <= state_nxt == bus_master_pkg::ST_IDLE;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			addr_r <= bus_master_pkg::ADDR_RST;
			be_r <= bus_master_pkg::BE_RST;
			addr_valid_r <= 1'b0;
			write_r <= 1'b0;
			instr_r <= 1'b0;
			burst_r <= 1'b0;
			first_r <= 1'b0;
			last_r <= 1'b0;
			beat_r <= bus_master_pkg::BEAT_FIRST;
		end else begin
			addr_r <= addr_nxt;
			be_r <= be_nxt;
			addr_valid_r <= addr_valid_nxt;
			write_r <= write_nxt;
			instr_r <= instr_nxt;
			burst_r <= burst_nxt;
			first_r <= first_nxt;
			last_r <= last_nxt;
			beat_r <= beat_nxt;
		end
	end

	// Order pin caught per burst so a mid-burst change cannot scramble it
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			start_r <= 2'h0;
			sub_r <= 1'b0;
			wdata_r <= bus_master_pkg::DATA_RST;
		end else begin
			if (take) begin
				start_r <= req_addr[1:0];
				sub_r <= subblock_order_select;
			end
			if (take_write) begin
				wdata_r <= req_wdata;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			rd_left_r <= 3'h0;
			rd_wait_r <= 2'h0;
			wd_live_r <= 1'b0;
			wchk_r <= 1'b0;
		end else begin
			rd_left_r <= rd_left_nxt;
			rd_wait_r <= rd_wait_nxt;
			wd_live_r <= wd_live_nxt;
			// error sampled one clock after write ready
			wchk_r <= wd_ack;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			rsp_valid_r <= 1'b0;
			rsp_data_r <= bus_master_pkg::DATA_RST;
			rsp_error_r <= 1'b0;
			rsp_last_r <= 1'b0;
			wr_done_r <= 1'b0;
			wr_error_r <= 1'b0;
		end else begin
			rsp_valid_r <= got;
			rsp_error_r <= got && read_bus_error_in;
			rsp_last_r <= got && (rd_left_r == 3'h1);
			if (got) begin
				rsp_data_r <= read_data_in;
			end
			wr_done_r <= wchk_r;
			wr_error_r <= wchk_r && write_bus_error_in;
		end
	end

	assign req_ready = req_ready_r;
	assign rsp_valid = rsp_valid_r;
	assign rsp_data = rsp_data_r;
	assign rsp_error = rsp_error_r;
	assign rsp_last = rsp_last_r;
	assign wr_done = wr_done_r;
	assign wr_error = wr_error_r;
	assign bus_word_address = addr_r;
	assign bus_byte_enables = be_r;
	assign address_valid_out = addr_valid_r;
	assign write_direction = write_r;
	assign instruction_fetch_flag = instr_r;
	assign burst_indicator = burst_r;
	assign burst_first_marker = first_r;
	assign burst_last_marker = last_r;
	assign write_data_out = wdata_r;

	// Helper: addresses accepted (address valid and address ready) in the current burst
	logic [2:0] chk_beats_r;
	always_ff @(posedge clk_sys) begin
		if (!rst_b || take) begin
			chk_beats_r <= 3'h0;
		end else if (addr_take && burst_r) begin
			chk_beats_r <= 3'(chk_beats_r + 3'h1);
		end
	end

	sequence s_single_rd_go;
		address_valid_out && address_ready_in && !burst_indicator && !write_direction;
	endsequence

	sequence s_burst_go;
		burst_first_marker && address_ready_in;
	endsequence

	property p_issue;
		@(posedge clk_sys) disable iff (!rst_b)
		req_valid && req_ready |=> address_valid_out && bus_word_address == $past(req_addr);
	endproperty
	a_issue: assert property (p_issue) else $error("address not issued at once");

	property p_hold;
		@(posedge clk_sys) disable iff (!rst_b)
		address_valid_out && !address_ready_in |=> address_valid_out &&
			$stable(bus_word_address) && $stable(bus_byte_enables);
	endproperty
	a_hold: assert property (p_hold) else $error("address dropped before ready");

	property p_fill_be;
		@(posedge clk_sys) disable iff (!rst_b)
		burst_indicator |-> bus_byte_enables == 4'hf;
	endproperty
	a_fill_be: assert property (p_fill_be) else $error("burst enables not full");

	property p_single_instr;
		@(posedge clk_sys) disable iff (!rst_b)
		req_valid && req_ready && req_op == bus_master_pkg::OP_READ
			|=> instruction_fetch_flag == $past(req_instr) && !burst_indicator;
	endproperty
	a_single_instr: assert property (p_single_instr) else $error("single read flag wrong");

	property p_valid_drop;
		@(posedge clk_sys) disable iff (!rst_b)
		address_valid_out && address_ready_in && !burst_indicator |=> !address_valid_out;
	endproperty
	a_valid_drop: assert property (p_valid_drop) else $error("valid without address");

	property p_read_dir;
		@(posedge clk_sys) disable iff (!rst_b)
		req_valid && req_ready && req_op != bus_master_pkg::OP_WRITE
			|=> !write_direction && address_valid_out;
	endproperty
	a_read_dir: assert property (p_read_dir) else $error("read drove write");

	property p_single_sample;
		@(posedge clk_sys) disable iff (!rst_b)
		s_single_rd_go ##1 read_valid_in |=> rsp_valid && rsp_data == $past(read_data_in);
	endproperty
	a_single_sample: assert property (p_single_sample) else $error("single read missed");

	property p_write_dir;
		@(posedge clk_sys) disable iff (!rst_b)
		req_valid && req_ready && req_op == bus_master_pkg::OP_WRITE
			|=> write_direction && address_valid_out;
	endproperty
	a_write_dir: assert property (p_write_dir) else $error("write not flagged");

	property p_wdata;
		@(posedge clk_sys) disable iff (!rst_b)
		req_valid && req_ready && req_op == bus_master_pkg::OP_WRITE
			|=> write_data_out == $past(req_wdata);
	endproperty
	a_wdata: assert property (p_wdata) else $error("write data late");

	property p_last_count;
		@(posedge clk_sys) disable iff (!rst_b)
		burst_last_marker |-> chk_beats_r == 3'h3 && burst_indicator;
	endproperty
	a_last_count: assert property (p_last_count) else $error("burst not four words");

	property p_seq_order;
		@(posedge clk_sys) disable iff (!rst_b)
		burst_indicator && address_ready_in && !burst_last_marker && !sub_r
			|=> bus_word_address[1:0] == 2'($past(bus_word_address[1:0]) + 2'h1);
	endproperty
	a_seq_order: assert property (p_seq_order) else $error("sequential order wrong");

	property p_sub_order;
		@(posedge clk_sys) disable iff (!rst_b)
		burst_indicator && address_ready_in && !burst_last_marker && sub_r
			|=> bus_word_address[1:0] == (start_r ^ 2'($past(chk_beats_r[1:0]) + 2'h1));
	endproperty
	a_sub_order: assert property (p_sub_order) else $error("sub-block order wrong");

	property p_burst_ind;
		@(posedge clk_sys) disable iff (!rst_b)
		burst_first_marker |-> burst_indicator && address_valid_out && !burst_last_marker;
	endproperty
	a_burst_ind: assert property (p_burst_ind) else $error("burst flag missing");

	property p_markers;
		@(posedge clk_sys) disable iff (!rst_b)
		s_burst_go |=> !burst_first_marker;
	endproperty
	a_markers: assert property (p_markers) else $error("first marker stuck");

	property p_burst_instr;
		@(posedge clk_sys) disable iff (!rst_b)
		req_valid && req_ready && req_op == bus_master_pkg::OP_BURST && req_instr
			|=> instruction_fetch_flag && burst_indicator;
	endproperty
	a_burst_instr: assert property (p_burst_instr) else $error("fill not flagged");

	property p_burst_gap;
		@(posedge clk_sys) disable iff (!rst_b)
		s_burst_go ##1 read_valid_in |=> !rsp_valid;
	endproperty
	a_burst_gap: assert property (p_burst_gap) else $error("burst sampled early");

	property p_burst_take;
		@(posedge clk_sys) disable iff (!rst_b)
		s_burst_go ##2 read_valid_in |=> rsp_valid;
	endproperty
	a_burst_take: assert property (p_burst_take) else $error("burst word missed");

	property p_burst_wait;
		@(posedge clk_sys) disable iff (!rst_b)
		burst_indicator && !address_ready_in |=> $stable(bus_word_address) && burst_indicator;
	endproperty
	a_burst_wait: assert property (p_burst_wait) else $error("burst advanced early");

	property p_burst_valid;
		@(posedge clk_sys) disable iff (!rst_b)
		burst_indicator && address_ready_in && !burst_last_marker |=> address_valid_out;
	endproperty
	a_burst_valid: assert property (p_burst_valid) else $error("burst valid gap");

	property p_burst_read;
		@(posedge clk_sys) disable iff (!rst_b)
		burst_indicator |-> !write_direction;
	endproperty
	a_burst_read: assert property (p_burst_read) else $error("burst read wrote");

endmodule

// File: sim/far_end_model.sv
// Far-end bus controller model answering the master port
`timescale 1ns/10ps
module far_end_model (
	input logic clk_sys,
	input logic rst_b,
	input logic slow,
	input logic err_en,
	input logic [33:0] err_addr,
	input logic [33:0] bus_word_address,
	input logic address_valid_out,
	input logic write_direction,
	input logic burst_indicator,
	output logic address_ready_in = 1'b0,
	output logic [31:0] read_data_in = 32'h0,
	output logic read_valid_in = 1'b0,
	output logic read_bus_error_in = 1'b0,
	output logic write_data_ready_in = 1'b0,
	output logic write_bus_error_in = 1'b0
);
	logic [33:0] rq_addr[$];
	int rq_due[$];
	int cyc = 0;
	logic wpend = 1'b0;
	logic wdir_q = 1'b0;
	logic wtook = 1'b0;
	logic wrise;
	assign wrise = write_direction && !wdir_q;

	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		wdir_q <= write_direction;
		wtook <= write_data_ready_in;
		if (write_data_ready_in)
			wpend <= 1'b0;
		else if (wrise)
			wpend <= 1'b1;
		if (!rst_b) begin
			rq_addr.delete();
			rq_due.delete();
		end else begin
			if (read_valid_in && rq_addr.size() > 0) begin
				void'(rq_addr.pop_front());
				void'(rq_due.pop_front());
			end
			// Earliest legal return: next edge for singles, two for bursts
			if (address_valid_out && address_ready_in && !write_direction) begin
				rq_addr.push_back(bus_word_address);
				rq_due.push_back(cyc + (burst_indicator ? 2 : 1));
			end
		end
	end

	always @(negedge clk_sys) begin
		address_ready_in <= !slow || (cyc % 3 != 0);
		if (rq_addr.size() > 0 && cyc >= rq_due[0] && !(slow && cyc % 2 == 0)) begin
			read_valid_in <= 1'b1;
			read_data_in <= rq_addr[0][31:0] ^ 32'h5a3c_96e1;
			read_bus_error_in <= err_en && rq_addr[0] == err_addr;
		end else begin
			read_valid_in <= 1'b0;
			read_data_in <= ~read_data_in;
			read_bus_error_in <= 1'b0;
		end
		write_data_ready_in <= (wpend || wrise) && !(slow && cyc % 2 == 0);
		write_bus_error_in <= err_en && wtook;
	end
endmodule

// File: sim/tb.sv
// Self-checking bench for the pipelined bus master port
`timescale 1ns/10ps
module tb;
	logic clk_sys = 1'b0;
	logic rst_b = 1'b0;
	logic req_valid = 1'b0, req_instr = 1'b0, sub_sel = 1'b0;
	logic [1:0] req_op = 2'h0;
	logic [33:0] req_addr = 34'h0, err_addr = 34'h0;
	logic [3:0] req_be = 4'h0;
	logic [31:0] req_wdata = 32'h0;
	logic slow = 1'b0, err_en = 1'b0;
	logic req_ready, rsp_valid, rsp_error, rsp_last, wr_done, wr_error;
	logic [31:0] rsp_data, write_data_out, read_data_in;
	logic [33:0] bus_word_address;
	logic [3:0] bus_byte_enables;
	logic address_valid_out, address_ready_in, write_direction, instruction_fetch_flag;
	logic burst_indicator, burst_first_marker, burst_last_marker;
	logic read_valid_in, read_bus_error_in, write_data_ready_in, write_bus_error_in;
	logic [42:0] acc_q[$];
	logic [33:0] rsp_q[$];
	logic [31:0] wd_q[$];
	logic wr_q[$];
	int acc_cyc[$], rsp_cyc[$];
	int cyc = 0, take_cyc = 0, n_errors = 0, comparisons = 0;

	always #2.5 clk_sys = ~clk_sys;

	pipelined_bus_master_port pipelined_bus_master_port_inst (.clk_sys(clk_sys), .rst_b(rst_b),
		.req_valid(req_valid), .req_ready(req_ready), .req_op(req_op), .req_addr(req_addr),
		.req_be(req_be), .req_wdata(req_wdata), .req_instr(req_instr), .rsp_valid(rsp_valid),
		.rsp_data(rsp_data), .rsp_error(rsp_error), .rsp_last(rsp_last), .wr_done(wr_done),
		.wr_error(wr_error), .bus_word_address(bus_word_address),
		.bus_byte_enables(bus_byte_enables), .address_valid_out(address_valid_out),
		.address_ready_in(address_ready_in), .write_direction(write_direction),
		.instruction_fetch_flag(instruction_fetch_flag), .burst_indicator(burst_indicator),
		.burst_first_marker(burst_first_marker), .burst_last_marker(burst_last_marker),
		.subblock_order_select(sub_sel), .read_data_in(read_data_in),
		.read_valid_in(read_valid_in), .read_bus_error_in(read_bus_error_in),
		.write_data_out(write_data_out), .write_data_ready_in(write_data_ready_in),
		.write_bus_error_in(write_bus_error_in));

	far_end_model far_end_model_inst (.clk_sys(clk_sys), .rst_b(rst_b), .slow(slow),
		.err_en(err_en), .err_addr(err_addr), .bus_word_address(bus_word_address),
		.address_valid_out(address_valid_out), .write_direction(write_direction),
		.burst_indicator(burst_indicator), .address_ready_in(address_ready_in),
		.read_data_in(read_data_in), .read_valid_in(read_valid_in),
		.read_bus_error_in(read_bus_error_in), .write_data_ready_in(write_data_ready_in),
		.write_bus_error_in(write_bus_error_in));

	// Log every accepted address and every returned word, with its edge
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (address_valid_out && address_ready_in) begin
			acc_q.push_back({write_direction, instruction_fetch_flag, burst_indicator,
				burst_first_marker, burst_last_marker, bus_byte_enables, bus_word_address});
			acc_cyc.push_back(cyc);
		end
		if (rsp_valid) begin
			rsp_q.push_back({rsp_error, rsp_last, rsp_data});
			rsp_cyc.push_back(cyc);
		end
		if (write_data_ready_in)
			wd_q.push_back(write_data_out);
		if (wr_done)
			wr_q.push_back(wr_error);
		if (cyc >= 5000) begin
			n_errors++;
			tally_and_finish();
		end
	end

	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %0t mismatch seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic do_req(input logic [1:0] op, input logic [33:0] a, input logic instr,
		input logic [3:0] be, input logic [31:0] wd);
		int n;
		acc_q.delete(); acc_cyc.delete(); rsp_q.delete(); rsp_cyc.delete();
		wd_q.delete(); wr_q.delete();
		@(negedge clk_sys);
		req_valid = 1'b1; req_op = op; req_addr = a; req_instr = instr;
		req_be = be; req_wdata = wd;
		n = 0;
		do begin @(posedge clk_sys); n++; end while (req_ready !== 1'b1 && n < 100);
		take_cyc = cyc;
		@(negedge clk_sys);
		req_valid = 1'b0;
		n = 0;
		do begin @(posedge clk_sys); n++; end while (req_ready !== 1'b1 && n < 200);
	endtask

	task automatic t_single_read(input logic [33:0] a, input logic instr, input logic er,
		input logic sl);
		slow = sl; err_en = er; err_addr = a;
		do_req(bus_master_pkg::OP_READ, a, instr, 4'h6, 32'h0);
		chk(acc_q.size(), 1);
		chk(acc_q[0], {1'b0, instr, 3'h0, 4'h6, a});
		chk(rsp_q.size(), 1);
		chk(rsp_q[0], {er, 1'b1, a[31:0] ^ 32'h5a3c_96e1});
		if (!sl) begin
			chk(acc_cyc[0] - take_cyc, 1);
			chk(rsp_cyc[0] - acc_cyc[0], 2);
		end
		$display("single read done slow=%0d", sl);
	endtask

	task automatic t_write(input logic [33:0] a, input logic [31:0] wd, input logic er,
		input logic sl);
		slow = sl; err_en = er;
		do_req(bus_master_pkg::OP_WRITE, a, 1'b0, 4'h3, wd);
		chk(acc_q.size(), 1);
		chk(acc_q[0], {1'b1, 4'h0, 4'h3, a});
		chk(wd_q.size(), 1);
		chk(wd_q[0], wd);
		chk(wr_q.size(), 1);
		chk(wr_q[0], er);
		chk(rsp_q.size(), 0);
		$display("single write done slow=%0d", sl);
	endtask

	task automatic t_burst(input logic [1:0] st, input logic sub, input logic instr,
		input logic sl, input logic [1:0] ek);
		logic [33:0] a, ea;
		logic [1:0] w, kk;
		a = {32'h2468_ace1, st};
		slow = sl; err_en = 1'b1; sub_sel = sub;
		err_addr = {a[33:2], sub ? (st ^ ek) : (st + ek)};
		do_req(bus_master_pkg::OP_BURST, a, instr, 4'h1, 32'h0);
		sub_sel = 1'b0;
		chk(acc_q.size(), 4);
		chk(rsp_q.size(), 4);
		for (int k = 0; k < 4; k++) begin
			kk = k[1:0];
			w = sub ? (st ^ kk) : (st + kk);
			ea = {a[33:2], w};
			chk(acc_q[k], {1'b0, instr, 1'b1, k == 0, k == 3, bus_master_pkg::BE_FULL, ea});
			chk(rsp_q[k], {kk == ek, k == 3, ea[31:0] ^ 32'h5a3c_96e1});
		end
		if (!sl)
			chk(rsp_cyc[0] - acc_cyc[0], 3);
		$display("burst done start=%0d sub=%0d slow=%0d", st, sub, sl);
	endtask

	initial begin
		repeat (3) @(posedge clk_sys);
		@(negedge clk_sys);
		rst_b = 1'b1;
		t_single_read(34'h1_2345_6789, 1'b1, 1'b0, 1'b0);
		t_single_read(34'h2_0000_0004, 1'b0, 1'b1, 1'b1);
		t_write(34'h3_0000_0010, 32'hcafe_f00d, 1'b0, 1'b0);
		t_write(34'h0_8000_0021, 32'h1234_5678, 1'b1, 1'b1);
		for (int s = 0; s < 4; s++) begin
			for (int b = 0; b < 2; b++) begin
				t_burst(s[1:0], b[0], s[0], b[0] ^ s[1], 2'(s + 1));
			end
		end
		tally_and_finish();
	end
endmodule
